// File: hdl/occr_cmd_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - code 100 returns error register contents
// - code 001 loads configuration from frame
// - code 101 returns configuration on bits 9-0
// - mode 000 and 100 mean standby
// - mode 1 bipolar, 2/3 unipolar current
// - mode 5 bipolar, 6 ten-volt, 7 five-volt
// - modes 2 and 3 decode identically
// - bits 6-4 pick brownout threshold, 10-24V
// - bit 3 enables thermal protection
// - error bit 9 flags intermittent fault
// - standard part: overcurrent bit in all modes
// - alternative part: overcurrent only in voltage modes
// - standard part: open load needs no short
// - alternative part: open load ignores short
// - error bit 6 flags die overtemperature
// - error bit 5 flags supply brownout
// - reserved codes inert, no-op returns zero
// - configuration applies at fourteenth falling edge
// - intermittent from cleared short or open only
// - fault output only for new errors
module occr_cmd_regs
  import occr_pkg::*;
#(
  parameter int unsigned               FAULT_CNT  = occr_pkg::FAULT_CYCLES,
  parameter bit                        ALT_VARIANT = 1'b0
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // serial link pins
  input  wire logic                    cs1_n_i,
  input  wire logic                    cs2_n_i,
  input  wire logic                    sclk_i,
  input  wire logic                    din_i,
  output logic                         dout_o,
  output logic                         dout_oe_n_o,
  output logic                         ready_n_o,
  output logic                         fault_irq_o,
  output logic                         fault_irq_oe_n_o,
  // analog monitor comparators
  input  wire logic                    overcurrent_i,
  input  wire logic                    rail_near_i,
  input  wire logic                    overtemp_i,
  input  wire logic [7:0]              supply_above_step_i,
  // decoded configuration to the output stage
  output logic                         op_standby_o,
  output logic                         op_current_o,
  output logic                         op_bipolar_o,
  output logic                         op_half_span_o,
  output logic [2:0]                   brownout_threshold_select_o,
  output logic                         thermal_protect_en_o
);

  localparam int unsigned SYNC_W = 15;
  // deselected and healthy supplies, so a flushed synchroniser starts no frame or fault
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {8'hff, 5'h00, 2'b11};
  localparam logic [FAULT_CNT_W-1:0] FAULT_LIMIT = FAULT_CNT_W'(FAULT_CNT);

  // ---------------------------------------------------------------
  // synchronised pins and monitor levels
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync_w;
  logic              cs1_n_s;
  logic              cs2_n_s;
  logic              sclk_s;
  logic              din_s;
  logic              ocur_s;
  logic              rail_s;
  logic              otemp_s;
  logic [7:0]        above_s;

  // every pin and comparator is asynchronous to clk_i
  occr_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_IDLE)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({supply_above_step_i, overtemp_i, rail_near_i, overcurrent_i,
               din_i, sclk_i, cs2_n_i, cs1_n_i}),
    .sync_o  (sync_w)
  );

  // unpack the synchronised group
  assign cs1_n_s = sync_w[0];
  assign cs2_n_s = sync_w[1];
  assign sclk_s  = sync_w[2];
  assign din_s   = sync_w[3];
  assign ocur_s  = sync_w[4];
  assign rail_s  = sync_w[5];
  assign otemp_s = sync_w[6];
  assign above_s = sync_w[14:7];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  occr_link_t        state_ff;
  occr_link_t        nxt_state;
  logic              sclk_prev_ff;
  logic [4:0]        fall_cnt_ff;
  logic [4:0]        nxt_fall_cnt;
  logic [15:0]       shift_ff;
  logic [15:0]       nxt_shift;
  logic [2:0]        cmd_ff;
  logic [2:0]        nxt_cmd;
  logic [15:0]       rd_word_ff;
  logic [15:0]       nxt_rd_word;
  logic              dout_ff;
  logic              nxt_dout;
  logic [CFG_W-1:0]  cfg_ff;
  logic [CFG_W-1:0]  nxt_cfg;
  logic [ERR_W-1:0]  err_ff;
  logic [ERR_W-1:0]  nxt_err;
  logic [3:0]        rep_ff;
  logic [3:0]        nxt_rep;
  logic              irq_ff;
  logic              nxt_irq;

  // ---------------------------------------------------------------
  // link edge and frame decode
  // ---------------------------------------------------------------
  wire        cs_active  = ~cs1_n_s & ~cs2_n_s;
  wire        sclk_fall  = sclk_prev_ff & ~sclk_s;
  wire        sclk_rise  = ~sclk_prev_ff & sclk_s;
  wire        in_shift   = (state_ff == LK_SHIFT);
  wire        shift_fall = in_shift & cs_active & sclk_fall;
  wire        shift_rise = in_shift & cs_active & sclk_rise;
  wire [4:0]  fall_next  = fall_cnt_ff + 5'h01;
  wire [15:0] shift_in   = {shift_ff[14:0], din_s};
  // command bits arrive complete at the fifth falling edge
  wire        cmd_edge   = shift_fall & (fall_next == FALL_CMD_DONE);
  wire [2:0]  cmd_now    = shift_in[2:0];
  wire        cfg_edge   = shift_fall & (fall_next == FALL_CFG_APPLY);
  wire        frame_end  = shift_fall & (fall_next == FALL_FRAME_END);
  // bit position presented on dout at the next rising edge, for the following falling edge
  wire [3:0]  out_idx    = 4'hf - fall_cnt_ff[3:0];

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // error readback command
  wire        cmd_rd_err = (cmd_now == CMD_RD_ERR);
  wire        cmd_rd_cfg = (cmd_now == CMD_RD_CFG);
  // reading errors clears the sticky bits
  wire        err_rd     = cmd_edge & cmd_rd_err;
  // write of configuration is armed by the command field
  wire        cfg_wr     = cfg_edge & (cmd_ff == CMD_WR_CFG);

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  wire [2:0]  mode_w     = cfg_ff[CFG_MODE_LO +: 3];

  // both standby codes stop the output
  assign op_standby_o   = (mode_w == MODE_STBY_A) | (mode_w == MODE_STBY_B);
  // current modes are codes 1 to 3, the low half of the codes without standby code 0
  assign op_current_o   = (mode_w == MODE_BI_CUR) | (mode_w == MODE_UNI_CUR_A) |
                          (mode_w == MODE_UNI_CUR_B);
  assign op_bipolar_o   = (mode_w == MODE_BI_CUR) | (mode_w == MODE_BI_VOLT);
  assign op_half_span_o = (mode_w == MODE_UNI_5V);
  // codes 2 and 3 share every decoded output above

  wire        volt_mode  = (mode_w == MODE_BI_VOLT) | (mode_w == MODE_UNI_10V) |
                           (mode_w == MODE_UNI_5V);

  // threshold code straight to the brownout comparator bank
  assign brownout_threshold_select_o = cfg_ff[CFG_BOT_LO +: 3];
  assign thermal_protect_en_o        = cfg_ff[CFG_THERM_BIT];

  // ---------------------------------------------------------------
  // fault conditions
  // ---------------------------------------------------------------
  logic short_q;
  logic open_q;

  // standard part qualifies overcurrent in every mode
  // alternative part qualifies it only in voltage modes
  wire short_cond = ocur_s & (!ALT_VARIANT | volt_mode);
  // standard part needs no short alongside a rail hit
  // alternative part takes the rail hit alone
  wire open_cond  = rail_s & (ALT_VARIANT | ~ocur_s);

  // overcurrent must persist for the full fault time
  occr_persist #(
    .CNT_W   (FAULT_CNT_W)
  ) u_short_persist (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .limit_i (FAULT_LIMIT),
    .cond_i  (short_cond),
    .qual_o  (short_q)
  );

  // rail proximity must persist for the full fault time
  occr_persist #(
    .CNT_W   (FAULT_CNT_W)
  ) u_open_persist (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .limit_i (FAULT_LIMIT),
    .cond_i  (open_cond),
    .qual_o  (open_q)
  );

  // brownout when the chosen step is not cleared by both supplies
  wire       brown_live = ~above_s[brownout_threshold_select_o];
  // overtemperature straight from the die detector
  wire [3:0] live_w     = {short_q, open_q, otemp_s, brown_live};
  wire [3:0] err_flt    = err_ff[ERR_BROWN +: 4];
  wire [3:0] rd_mask    = err_rd ? err_flt : 4'h0;

  // only a latched short or open that has gone away is intermittent
  // a bit being cleared by this read no longer counts, so the read also clears bit 9
  wire intermit_set = (err_ff[ERR_SHORT] & ~rd_mask[3] & ~short_q) |
                      (err_ff[ERR_OPEN] & ~rd_mask[2] & ~open_q);

  // a fault is new when it is live and not yet reported
  wire new_fault    = |(live_w & ~rep_ff & ~rd_mask);

  // ---------------------------------------------------------------
  // link state machine
  // ---------------------------------------------------------------
  // dropping either select abandons the frame at once
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LK_IDLE: begin
        if (cs_active) begin
          nxt_state = LK_SHIFT;
        end
      end
      LK_SHIFT: begin
        if (!cs_active) begin
          nxt_state = LK_IDLE;
        end else if (frame_end) begin
          nxt_state = LK_DONE;
        end
      end
      LK_DONE: begin
        if (!cs_active) begin
          nxt_state = LK_IDLE;
        end
      end
      default: begin
        nxt_state = LK_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // shifter, command capture and readback word
  // ---------------------------------------------------------------
  always_comb begin
    nxt_fall_cnt = fall_cnt_ff;
    nxt_shift    = shift_ff;
    nxt_cmd      = cmd_ff;
    nxt_rd_word  = rd_word_ff;
    nxt_dout     = dout_ff;
    if (state_ff == LK_IDLE) begin
      nxt_fall_cnt = 5'h00;
      nxt_shift    = 16'h0000;
      nxt_cmd      = CMD_NOP;
      nxt_rd_word  = 16'h0000;
      nxt_dout     = 1'b0;
    end else if (shift_fall) begin
      nxt_fall_cnt = fall_next;
      nxt_shift    = shift_in;
      if (cmd_edge) begin
        nxt_cmd = cmd_now;
        // no-op, write and reserved codes answer with zeros
        // bits above the fields read as zero
        if (cmd_rd_err) begin
          nxt_rd_word = {6'h00, err_ff};
        end else if (cmd_rd_cfg) begin
          nxt_rd_word = {6'h00, cfg_ff};
        end else begin
          nxt_rd_word = 16'h0000;
        end
      end
    end else if (shift_rise) begin
      // host samples dout on the following falling edge
      nxt_dout = rd_word_ff[out_idx];
    end
  end

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  // takes effect on the fourteenth falling edge, bits 9-3 known
  // fourteen bits in, frame bit n sits at shift position n-2
  // reserved bits never stored
  assign nxt_cfg = cfg_wr ? ({nxt_shift[CFG_W-3:0], 2'b00} & CFG_WR_MASK) : cfg_ff;

  // ---------------------------------------------------------------
  // error register, reported set and fault output
  // ---------------------------------------------------------------
  // a live fault wins over the read clear in the same cycle
  always_comb begin
    nxt_err                   = err_ff;
    nxt_err[ERR_BROWN +: 4]   = (err_flt & ~rd_mask) | live_w;
    // intermittent flag in bit 9, cleared by the read
    nxt_err[ERR_INTERMIT]     = (err_ff[ERR_INTERMIT] & ~err_rd) | intermit_set;
    nxt_err[ERR_BROWN-1:0]    = '0;
    // a read marks what it showed as reported, and forgets what it did not
    nxt_rep                   = err_rd ? err_flt : rep_ff;
    // set by a new fault, cleared by reading the error register
    nxt_irq                   = (irq_ff & ~err_rd) | new_fault;
  end

  // ---------------------------------------------------------------
  // flip-flops
  // ---------------------------------------------------------------
  // link side registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff     <= LK_IDLE;
      sclk_prev_ff <= 1'b0;
      fall_cnt_ff  <= 5'h00;
      shift_ff     <= 16'h0000;
      cmd_ff       <= CMD_NOP;
      rd_word_ff   <= 16'h0000;
      dout_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      sclk_prev_ff <= sclk_s;
      fall_cnt_ff  <= nxt_fall_cnt;
      shift_ff     <= nxt_shift;
      cmd_ff       <= nxt_cmd;
      rd_word_ff   <= nxt_rd_word;
      dout_ff      <= nxt_dout;
    end
  end

  // register file and fault bookkeeping
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_ff <= CFG_RST;
      err_ff <= ERR_RST;
      rep_ff <= FLT_RST;
      irq_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      err_ff <= nxt_err;
      rep_ff <= nxt_rep;
      irq_ff <= nxt_irq;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // dout is driven only inside the sixteen-bit frame, released after
  assign dout_o           = dout_ff;
  assign dout_oe_n_o      = ~in_shift;
  // ready marks a fully processed frame until select rises
  assign ready_n_o        = ~(state_ff == LK_DONE);
  // open-drain fault line: pulls low while a fault is pending
  assign fault_irq_o      = 1'b0;
  assign fault_irq_oe_n_o = ~irq_ff;

endmodule : occr_cmd_regs

// File: hdl/occr_pkg.sv
package occr_pkg;

  // clock and fault persistence timing
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned FAULT_TIME_MS  = 620;
  localparam int unsigned FAULT_CYCLES   = FAULT_TIME_MS * CLK_PER_MS;
  localparam int unsigned FAULT_CNT_W    = 24;

  // frame layout, counted in serial clock falling edges
  localparam int unsigned FRAME_BITS     = 16;
  localparam logic [4:0]  FALL_CMD_DONE  = 5'h05;
  localparam logic [4:0]  FALL_CFG_APPLY = 5'h0e;
  localparam logic [4:0]  FALL_FRAME_END = 5'h10;

  // command codes in frame bits 13 to 11
  localparam logic [2:0]  CMD_NOP        = 3'h0;
  localparam logic [2:0]  CMD_WR_CFG     = 3'h1;
  localparam logic [2:0]  CMD_RD_ERR     = 3'h4;
  localparam logic [2:0]  CMD_RD_CFG     = 3'h5;

  // configuration register field positions
  localparam int unsigned CFG_W          = 10;
  localparam int unsigned CFG_MODE_LO    = 7;
  localparam int unsigned CFG_BOT_LO     = 4;
  localparam int unsigned CFG_THERM_BIT  = 3;
  localparam logic [9:0]  CFG_WR_MASK    = 10'h3f8;
  localparam logic [9:0]  CFG_RST        = 10'h000;

  // error register bit positions
  localparam int unsigned ERR_W          = 10;
  localparam int unsigned ERR_INTERMIT   = 9;
  localparam int unsigned ERR_SHORT      = 8;
  localparam int unsigned ERR_OPEN       = 7;
  localparam int unsigned ERR_OTEMP      = 6;
  localparam int unsigned ERR_BROWN      = 5;
  localparam logic [9:0]  ERR_RST        = 10'h000;
  localparam logic [3:0]  FLT_RST        = 4'h0;

  // operating mode codes
  localparam logic [2:0]  MODE_STBY_A    = 3'h0;
  localparam logic [2:0]  MODE_BI_CUR    = 3'h1;
  localparam logic [2:0]  MODE_UNI_CUR_A = 3'h2;
  localparam logic [2:0]  MODE_UNI_CUR_B = 3'h3;
  localparam logic [2:0]  MODE_STBY_B    = 3'h4;
  localparam logic [2:0]  MODE_BI_VOLT   = 3'h5;
  localparam logic [2:0]  MODE_UNI_10V   = 3'h6;
  localparam logic [2:0]  MODE_UNI_5V    = 3'h7;

  // link frame state
  typedef enum logic [2:0] {
    LK_IDLE  = 3'b001,
    LK_SHIFT = 3'b010,
    LK_DONE  = 3'b100
  } occr_link_t;

endpackage : occr_pkg

// File: hdl/occr_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of independent single-bit levels
module occr_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage; reset to the idle pin levels
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : occr_sync

// File: hdl/occr_persist.sv
`timescale 1ns/1ps
// qualifies a condition once it has held without a break for limit_i cycles
module occr_persist #(
  parameter int unsigned CNT_W = 24
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [CNT_W-1:0] limit_i,
  input  wire logic             cond_i,
  output logic                  qual_o
);

  logic [CNT_W-1:0] cnt_ff;
  logic             qual_ff;
  wire              at_limit = (cnt_ff >= limit_i);

  // any break in the condition restarts the count; saturates at the limit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_ff  <= '0;
      qual_ff <= 1'b0;
    end else begin
      cnt_ff  <= !cond_i ? '0 : (at_limit ? cnt_ff : cnt_ff + 1'b1);
      qual_ff <= cond_i & at_limit;
    end
  end

  assign qual_o = qual_ff;

endmodule : occr_persist

// File: sim/occr_cmd_regs_sva.sv
`timescale 1ns/1ps
// port-level checks for the command register block
module occr_cmd_regs_sva
  import occr_pkg::*;
#(
  parameter int unsigned FAULT_CNT = 20
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       cs1_n_i,
  input wire logic       cs2_n_i,
  input wire logic       sclk_i,
  input wire logic       din_i,
  input wire logic       dout_o,
  input wire logic       dout_oe_n_o,
  input wire logic       ready_n_o,
  input wire logic       fault_irq_o,
  input wire logic       fault_irq_oe_n_o,
  input wire logic       overcurrent_i,
  input wire logic       rail_near_i,
  input wire logic       overtemp_i,
  input wire logic [7:0] supply_above_step_i,
  input wire logic       op_standby_o,
  input wire logic       op_current_o,
  input wire logic       op_bipolar_o,
  input wire logic       op_half_span_o,
  input wire logic [2:0] brownout_threshold_select_o,
  input wire logic       thermal_protect_en_o
);
  logic [3:0] quiet_ff;
  logic [3:0] nxt_quiet;
  logic       live_flt;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // cycles since any monitor flag was live; a fault line raised long after that is spurious
  assign live_flt  = overcurrent_i | rail_near_i | overtemp_i |
                     ~supply_above_step_i[brownout_threshold_select_o];
  assign nxt_quiet = live_flt ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
  always_ff @(posedge clk_i) begin
    quiet_ff <= rst_n_i ? nxt_quiet : 4'hf;
  end
  a_standby_no_drive: assert property (
    op_standby_o |-> !(op_current_o | op_bipolar_o | op_half_span_o)) else $error("standby drives");
  a_current_kind: assert property (
    op_current_o |-> !op_standby_o && !op_half_span_o) else $error("current mode mixed");
  a_half_span_volt: assert property (
    op_half_span_o |-> !(op_current_o | op_bipolar_o | op_standby_o)) else $error("half span mixed");
  a_idle_cfg_stable: assert property (
    cs1_n_i[*6] |-> $stable({op_standby_o, op_current_o, op_bipolar_o, op_half_span_o,
                             brownout_threshold_select_o, thermal_protect_en_o}))
    else $error("setup changed outside a frame");
  a_ready_frees_dout: assert property (
    !ready_n_o |-> dout_oe_n_o) else $error("data line driven after frame");
  a_cs_high_idle: assert property (
    cs1_n_i[*5] |=> dout_oe_n_o && ready_n_o) else $error("link not idle when deselected");
  a_ready_holds: assert property (
    !ready_n_o && !cs1_n_i && !cs2_n_i |=> !ready_n_o) else $error("ready dropped early");
  a_fault_new_only: assert property (
    $fell(fault_irq_oe_n_o) |-> quiet_ff < 4'h6) else $error("fault line without a fault");
  c_frame_done: cover property ($fell(ready_n_o));
  c_fault_raised: cover property ($fell(fault_irq_oe_n_o));
  c_mode_left: cover property ($fell(op_standby_o));
endmodule : occr_cmd_regs_sva

bind occr_cmd_regs occr_cmd_regs_sva #(.FAULT_CNT(FAULT_CNT)) i_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cs1_n_i(cs1_n_i), .cs2_n_i(cs2_n_i), .sclk_i(sclk_i),
  .din_i(din_i), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .ready_n_o(ready_n_o),
  .fault_irq_o(fault_irq_o), .fault_irq_oe_n_o(fault_irq_oe_n_o),
  .overcurrent_i(overcurrent_i), .rail_near_i(rail_near_i), .overtemp_i(overtemp_i),
  .supply_above_step_i(supply_above_step_i), .op_standby_o(op_standby_o),
  .op_current_o(op_current_o), .op_bipolar_o(op_bipolar_o), .op_half_span_o(op_half_span_o),
  .brownout_threshold_select_o(brownout_threshold_select_o),
  .thermal_protect_en_o(thermal_protect_en_o));

// File: sim/occr_host_model.sv
`timescale 1ns/1ps
// host end of the link: frames a word, samples the answer at each falling edge
module occr_host_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic        slow_i,
  input  wire logic [4:0]  n_fall_i,
  input  wire logic [15:0] tx_i,
  input  wire logic        dout_i,
  output logic             cs_n_o,
  output logic             sclk_o,
  output logic             din_o,
  output logic [15:0]      rx_o,
  output logic             done_o
);
  int i;
  int half;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
    rx_o   = 16'h0000;
    done_o = 1'b0;
  end
  // one frame per request; a short count of falls aborts it early
  always begin
    @(posedge clk_i);
    if (go_i) begin
      done_o = 1'b0;
      half   = slow_i ? 8 : 4;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      repeat (2 * half) @(negedge clk_i);
      for (i = 15; i > 15 - int'(n_fall_i); i--) begin
        // command in bits 13 to 11, launched on the rise
        sclk_o = 1'b1;
        din_o  = tx_i[i];
        repeat (half) @(negedge clk_i);
        sclk_o  = 1'b0;
        rx_o[i] = dout_i;
        repeat (half) @(negedge clk_i);
      end
      cs_n_o = 1'b1;
      din_o  = ~din_o; // released line keeps no stale value
      repeat (8) @(negedge clk_i);
      done_o = 1'b1;
    end
  end
endmodule : occr_host_model

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import occr_pkg::*;
  localparam int unsigned FCNT = 20; // short persistence keeps the run brief
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        go      = 1'b0;
  logic        slow    = 1'b0;
  logic [4:0]  n_fall  = 5'h10;
  logic [15:0] tx      = 16'h0000;
  logic        ovc     = 1'b0;
  logic        near    = 1'b0;
  logic        hot     = 1'b0;
  logic [7:0]  step    = 8'hff;
  logic        cs_n, sclk, din, done, dout, dout_oe_n, rdy_n, irq, irq_oe_n;
  logic        stby, cur, bip, half, therm;
  logic [2:0]  bot;
  logic [15:0] rx;
  logic [9:0]  cfg;
  wire logic   dout_w;
  wire logic   fault_w;
  wire logic [7:0] ops;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          m;
  // pull-ups on the released data line and the open-drain fault line
  assign dout_w  = dout_oe_n ? 1'b1 : dout;
  assign fault_w = irq_oe_n ? 1'b1 : irq;
  assign ops     = {stby, cur, bip, half, therm, bot};
  always #20 clk_i = ~clk_i;
  occr_cmd_regs #(.FAULT_CNT(FCNT), .ALT_VARIANT(1'b0)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs1_n_i(cs_n), .cs2_n_i(cs_n), .sclk_i(sclk),
    .din_i(din), .dout_o(dout), .dout_oe_n_o(dout_oe_n), .ready_n_o(rdy_n),
    .fault_irq_o(irq), .fault_irq_oe_n_o(irq_oe_n), .overcurrent_i(ovc),
    .rail_near_i(near), .overtemp_i(hot), .supply_above_step_i(step),
    .op_standby_o(stby), .op_current_o(cur), .op_bipolar_o(bip), .op_half_span_o(half),
    .brownout_threshold_select_o(bot), .thermal_protect_en_o(therm));
  occr_host_model i_host (
    .clk_i(clk_i), .go_i(go), .slow_i(slow), .n_fall_i(n_fall), .tx_i(tx),
    .dout_i(dout_w), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .rx_o(rx), .done_o(done));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk_word(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk_word
  task automatic chk_pin(input logic [7:0] e);
    n_tests++;
    if (ops !== e) begin
      bad_count++;
      $display("[ERR] op outputs expected %h seen %h", e, ops);
    end
  endtask : chk_pin
  task automatic chk_line(input logic e);
    n_tests++;
    if (fault_w !== e) begin
      bad_count++;
      $display("[ERR] fault line expected %b seen %b", e, fault_w);
    end
  endtask : chk_line
  // expected decode of mode, threshold and thermal bits
  function automatic logic [7:0] exp_op(input logic [9:0] c);
    logic [2:0] md;
    md = c[9:7];
    return {md[1:0] == 2'b00, !md[2] && md != 3'h0, md[1:0] == 2'b01, md == 3'h7, c[3], c[6:4]};
  endfunction : exp_op
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : idle
  // monitor inputs packed as over-current, rail, heat, supply bank
  task automatic mon(input logic [10:0] v, input int n);
    {ovc, near, hot, step} <= v;
    idle(n);
  endtask : mon
  // one frame; the answer word is compared only for complete frames
  task automatic xfer(input logic [2:0] c, input logic [10:0] d, input logic [15:0] e,
                      input logic [4:0] nf);
    int k;
    tx     <= {2'b00, c, d};
    n_fall <= nf;
    go     <= 1'b1;
    @(negedge clk_i);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 3000) begin
      bad_count++;
      report_and_stop();
    end
    if (nf == 5'h10) begin
      chk_word("dout word", e, rx);
    end
  endtask : xfer
  task automatic rd_err(input logic [15:0] e);
    xfer(CMD_RD_ERR, 11'h000, e, 5'h10);
  endtask : rd_err

  initial begin
    idle(4);
    rst_n_i <= 1'b1;
    idle(6);
    xfer(CMD_RD_CFG, 11'h000, 16'h0000, 5'h10);
    chk_pin(8'h80);
    $display("test reset done");
    for (m = 0; m < 8; m++) begin
      cfg = {3'(m), 3'(7 - m), 1'(m), 3'b111};
      xfer(CMD_WR_CFG, {1'b1, cfg}, 16'h0000, 5'h10);
      idle(2);
      chk_pin(exp_op(cfg));
      xfer(CMD_RD_CFG, 11'h7ff, {6'h00, cfg[9:3], 3'b000}, 5'h10);
    end
    $display("test modes done");
    for (m = 0; m < 8; m++) begin
      if (m != 1 && m != 4 && m != 5) begin
        xfer(3'(m), 11'h7ff, 16'h0000, 5'h10);
      end
    end
    xfer(CMD_RD_CFG, 11'h000, 16'h0388, 5'h10);
    $display("test reserved done");
    xfer(CMD_WR_CFG, 11'h0a8, 16'h0000, 5'h0d);
    slow <= 1'b1;
    xfer(CMD_RD_CFG, 11'h000, 16'h0388, 5'h10);
    xfer(CMD_WR_CFG, 11'h0a8, 16'h0000, 5'h0e);
    xfer(CMD_RD_CFG, 11'h000, 16'h00a8, 5'h10);
    slow <= 1'b0;
    $display("test abort done");
    mon(11'h4ff, 10);
    mon(11'h0ff, 6);
    rd_err(16'h0000);
    mon(11'h1ff, 8);
    chk_line(1'b0);
    rd_err(16'h0040);
    chk_line(1'b1);
    rd_err(16'h0040);
    chk_line(1'b1);
    mon(11'h0ff, 6);
    rd_err(16'h0040);
    rd_err(16'h0000);
    $display("test overtemperature done");
    mon(11'h2ff, 40);
    chk_line(1'b0);
    rd_err(16'h0080);
    mon(11'h0ff, 6);
    rd_err(16'h0280);
    rd_err(16'h0000);
    $display("test open load done");
    mon(11'h4ff, 30);
    mon(11'h6ff, 40);
    rd_err(16'h0100);
    mon(11'h0ff, 6);
    rd_err(16'h0300);
    rd_err(16'h0000);
    $display("test short done");
    mon(11'h007, 10);
    rd_err(16'h0000);
    mon(11'h003, 10);
    chk_line(1'b0);
    rd_err(16'h0020);
    mon(11'h0ff, 6);
    rd_err(16'h0020);
    rd_err(16'h0000);
    $display("test brownout done");
    report_and_stop();
  end
endmodule : tb
